// ===== rtl/tsw_core.v
// PCM time slot switch core with register port, selftest and test port.
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "tsw_regs.vh"
module tsw_core #(
  parameter [31:0] STEP_CYC = `TSW_STEP_NS / `TSW_CLK_NS,
  // Arbitrary identification value.
  parameter [31:0] ID_CODE = 32'h0A5C_3001
) (
  input wire clock,
  input wire rst,
  input wire [4:0] bus_addr,
  input wire [7:0] bus_wdata,
  input wire bus_wr,
  input wire bus_rd,
  output reg [7:0] bus_rdata,
  input wire [31:0] pcm_rx_line,
  input wire sync_pulse,
  input wire [5:0] frame_measure_input,
  output wire [31:0] pcm_tx_line,
  output wire [31:0] pcm_tx_oe_n,
  output reg int_out,
  output reg int_oe_n,
  input wire tck,
  input wire tms,
  input wire tdi,
  output reg tdo,
  output reg tdo_oe_n
);
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_STEP1 = 2'h1;
  localparam [1:0] ST_STEP2 = 2'h2;
  localparam [1:0] ST_CLEAR = 2'h3;
  localparam [3:0] TLR = 4'h0, RTI = 4'h1, SDS = 4'h2, CDR = 4'h3;
  localparam [3:0] SHDR = 4'h4, E1D = 4'h5, PDR = 4'h6, E2D = 4'h7;
  localparam [3:0] UDR = 4'h8, SIS = 4'h9, CIR = 4'hA, SHIR = 4'hB;
  localparam [3:0] E1I = 4'hC, PIR = 4'hD, E2I = 4'hE, UIR = 4'hF;

  reg [7:0] dm_a_q [0:2047];
  reg [7:0] dm_b_q [0:2047];
  reg [11:0] cm_a_q [0:1023];
  reg [11:0] cm_b_q [0:1023];
  reg [11:0] in_cnt_q;
  reg [11:0] out_cnt_q;
  reg sp_fall_q;
  reg sp_q;
  reg sp_prev_q;
  reg synced_q;
  reg [7:0] mode_q;
  reg [31:0] icss_q;
  reg [7:0] oshift_q;
  reg [11:0] edge_q;
  reg [7:0] ia_lo_q;
  reg [7:0] ia_hi_q;
  reg [7:0] id_lo_q;
  reg [4:0] irq_q;
  reg cmr_busy_q;
  reg [9:0] cmr_idx_q;
  reg ev_busy_q;
  reg [2:0] ev_sel_q;
  reg [5:0] fs_prev_q;
  reg [1:0] st_state_q;
  reg [31:0] st_cnt_q;
  reg st_err_q;
  reg st_ok_q;
  reg tck_s1_q, tck_s2_q, tck_s3_q;
  reg tms_s1_q, tms_s2_q, tdi_s1_q, tdi_s2_q;
  reg [3:0] tap_q;
  reg [3:0] tap_d;
  reg [1:0] ir_q;
  reg [1:0] ir_sh_q;
  reg [31:0] dr_sh_q;
  wire [255:0] rx_all;
  reg [7:0] rd_d;

  ////////////////////////////////////////////////////////////////////////////
  // Frame timing and synchronisation.
  wire sp_rise = sp_q & ~sp_prev_q;
  wire at_last = (in_cnt_q == `TSW_FRAME_LAST);
  wire ev_gain = sp_rise & at_last & ~synced_q;
  wire ev_lost = synced_q & (sp_rise ^ at_last);

  always @(negedge clock or posedge rst) begin
    if (rst)
      sp_fall_q <= 1'b0;
    else
      sp_fall_q <= sync_pulse;
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      sp_q <= 1'b0;
      sp_prev_q <= 1'b0;
      in_cnt_q <= 12'h000;
      out_cnt_q <= 12'h000;
    end else begin
      sp_q <= sp_fall_q;
      sp_prev_q <= sp_q;
      in_cnt_q <= sp_rise ? 12'h000 : in_cnt_q + 12'h001;
      out_cnt_q <= sp_rise ? 12'h000 - {4'h0, oshift_q} :
                   out_cnt_q + 12'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-line receive and transmit paths.
  genvar g;
  generate
    for (g = 0; g < 32; g = g + 1) begin : gen_line
      localparam [4:0] GI = g;
      wire [3:0] sidx = mode_q[`TSW_M_WIDE] ? GI[4:1] :
                        GI[3:0];
      wire [1:0] shv = icss_q[{sidx, 1'b0} +: 2];
      wire [9:0] cmi = {GI[3:0], out_cnt_q[11:6]};
      wire [11:0] ent = GI[4] ? cm_b_q[cmi] : cm_a_q[cmi];
      wire [7:0] byte_rd = GI[4] ? dm_b_q[ent[10:0]] :
                           dm_a_q[ent[10:0]];
      wire used = ~GI[4] | mode_q[`TSW_M_WIDE];
      reg [7:0] rx_sh_q;
      reg [7:0] tx_sh_q;
      reg ts_q;
      reg tx_bit_q;
      reg oe_n_q;
      assign rx_all[8*g +: 8] = rx_sh_q;
      assign pcm_tx_line[g] = tx_bit_q;
      assign pcm_tx_oe_n[g] = oe_n_q;
      always @(posedge clock or posedge rst) begin
        if (rst) begin
          rx_sh_q <= 8'h00;
          tx_sh_q <= 8'h00;
          ts_q <= 1'b1;
          tx_bit_q <= 1'b0;
          oe_n_q <= 1'b1;
        end else begin
          if (in_cnt_q[2:0] == {shv, 1'b0})
            rx_sh_q <= {rx_sh_q[6:0], pcm_rx_line[g]};
          if (out_cnt_q[5:0] == 6'h00) begin
            tx_sh_q <= byte_rd;
            ts_q <= ent[11];
          end else if (out_cnt_q[2:0] == 3'h0) begin
            tx_sh_q <= {tx_sh_q[6:0], 1'b0};
          end
          tx_bit_q <= tx_sh_q[7];
          oe_n_q <= ts_q | ~used;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Data and connection memories.
  integer i;
  wire cm_host_wr = bus_wr & (bus_addr == `TSW_A_IDHI) &
                    ~ia_hi_q[`TSW_IA_DM] & ~cmr_busy_q;
  wire [10:0] ia = {ia_hi_q[2:0], ia_lo_q};

  always @(posedge clock) begin
    if (in_cnt_q[5:0] == `TSW_SLOT_END) begin
      for (i = 0; i < 32; i = i + 1) begin
        dm_a_q[{in_cnt_q[11:6], i[4:0]}] <= rx_all[8*i +: 8];
        dm_b_q[{in_cnt_q[11:6], i[4:0]}] <= rx_all[8*i +: 8];
      end
    end
  end

  always @(posedge clock) begin
    if (cmr_busy_q) begin
      cm_a_q[cmr_idx_q] <= `TSW_CM_TRI;
      cm_b_q[cmr_idx_q] <= `TSW_CM_TRI;
    end else if (cm_host_wr) begin
      if (ia[10])
        cm_b_q[ia[9:0]] <= {bus_wdata[3:0], id_lo_q};
      else
        cm_a_q[ia[9:0]] <= {bus_wdata[3:0], id_lo_q};
    end
  end

  wire [11:0] cm_rd = ia[10] ? cm_b_q[ia[9:0]] : cm_a_q[ia[9:0]];
  wire [11:0] ind_rd = ia_hi_q[`TSW_IA_DM] ? {4'h0, dm_a_q[ia]} : cm_rd;
  wire st_mis = dm_a_q[st_cnt_q[10:0]] != dm_b_q[st_cnt_q[10:0]];

  ////////////////////////////////////////////////////////////////////////////
  // Test access port, sampled on the system clock.
  wire tck_rise = tck_s2_q & ~tck_s3_q;
  wire tck_fall = ~tck_s2_q & tck_s3_q;
  wire tap_st_go = tck_rise & (tap_q == UDR) & (ir_q == `TSW_IR_SELFTEST);

  always @* begin
    case (tap_q)
      TLR: tap_d = tms_s2_q ? TLR : RTI;
      RTI: tap_d = tms_s2_q ? SDS : RTI;
      SDS: tap_d = tms_s2_q ? SIS : CDR;
      CDR: tap_d = tms_s2_q ? E1D : SHDR;
      SHDR: tap_d = tms_s2_q ? E1D : SHDR;
      E1D: tap_d = tms_s2_q ? UDR : PDR;
      PDR: tap_d = tms_s2_q ? E2D : PDR;
      E2D: tap_d = tms_s2_q ? UDR : SHDR;
      UDR: tap_d = tms_s2_q ? SDS : RTI;
      SIS: tap_d = tms_s2_q ? TLR : CIR;
      CIR: tap_d = tms_s2_q ? E1I : SHIR;
      SHIR: tap_d = tms_s2_q ? E1I : SHIR;
      E1I: tap_d = tms_s2_q ? UIR : PIR;
      PIR: tap_d = tms_s2_q ? E2I : PIR;
      E2I: tap_d = tms_s2_q ? UIR : SHIR;
      UIR: tap_d = tms_s2_q ? SDS : RTI;
      default: tap_d = TLR;
    endcase
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      tck_s1_q <= 1'b0;
      tck_s2_q <= 1'b0;
      tck_s3_q <= 1'b0;
      tms_s1_q <= 1'b1;
      tms_s2_q <= 1'b1;
      tdi_s1_q <= 1'b1;
      tdi_s2_q <= 1'b1;
      tap_q <= TLR;
      ir_q <= `TSW_IR_IDCODE;
      ir_sh_q <= `TSW_IR_IDCODE;
      dr_sh_q <= 32'h0000_0000;
      tdo <= 1'b0;
      tdo_oe_n <= 1'b1;
    end else begin
      tck_s1_q <= tck;
      tck_s2_q <= tck_s1_q;
      tck_s3_q <= tck_s2_q;
      tms_s1_q <= tms;
      tms_s2_q <= tms_s1_q;
      tdi_s1_q <= tdi;
      tdi_s2_q <= tdi_s1_q;
      if (tck_rise) begin
        tap_q <= tap_d;
        if (tap_q == TLR)
          ir_q <= `TSW_IR_IDCODE;
        if (tap_q == CIR)
          ir_sh_q <= `TSW_IR_IDCODE;
        if (tap_q == SHIR)
          ir_sh_q <= {tdi_s2_q, ir_sh_q[1]};
        if (tap_q == UIR)
          ir_q <= ir_sh_q;
        if (tap_q == CDR) begin
          case (ir_q)
            `TSW_IR_IDCODE: dr_sh_q <= ID_CODE;
            `TSW_IR_SELFTEST:
              dr_sh_q <= {30'h0, st_state_q != ST_IDLE, st_ok_q};
            default: dr_sh_q <= 32'h0000_0000;
          endcase
        end
        if (tap_q == SHDR) begin
          if (ir_q == `TSW_IR_IDCODE)
            dr_sh_q <= {tdi_s2_q, dr_sh_q[31:1]};
          else if (ir_q == `TSW_IR_SELFTEST)
            dr_sh_q <= {30'h0, tdi_s2_q, dr_sh_q[1]};
          else
            dr_sh_q <= {31'h0, tdi_s2_q};
        end
      end
      if (tck_fall) begin
        tdo <= (tap_q == SHIR) ? ir_sh_q[0] : dr_sh_q[0];
        tdo_oe_n <= ~((tap_q == SHIR) | (tap_q == SHDR));
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers, special functions and interrupt line.
  wire wr_cmd = bus_wr & (bus_addr == `TSW_A_CMD);
  wire st_start = (wr_cmd & bus_wdata[`TSW_C_ST]) | tap_st_go;
  wire st_run = st_state_q != ST_IDLE;
  wire cmr_end = cmr_busy_q & (cmr_idx_q == `TSW_CMR_LAST);
  wire fs_hit = ev_busy_q & frame_measure_input[ev_sel_q] &
                ~fs_prev_q[ev_sel_q];
  wire st_step_end = st_cnt_q == STEP_CYC - 32'h1;
  wire st_done = (st_state_q == ST_CLEAR) & cmr_end;
  wire [4:0] irq_set = {st_done, fs_hit, cmr_end & ~st_run,
                        ev_gain, ev_lost};
  wire irq_clr = bus_rd & (bus_addr == `TSW_A_IRQ);

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      synced_q <= 1'b0;
      mode_q <= 8'h00;
      icss_q <= 32'h0000_0000;
      oshift_q <= 8'h00;
      edge_q <= 12'h000;
      ia_lo_q <= 8'h00;
      ia_hi_q <= 8'h00;
      id_lo_q <= 8'h00;
      irq_q <= 5'h00;
      cmr_busy_q <= 1'b0;
      cmr_idx_q <= 10'h000;
      ev_busy_q <= 1'b0;
      ev_sel_q <= 3'h0;
      fs_prev_q <= 6'h00;
      st_state_q <= ST_IDLE;
      st_cnt_q <= 32'h0000_0000;
      st_err_q <= 1'b0;
      st_ok_q <= 1'b0;
      int_out <= 1'b0;
      int_oe_n <= 1'b1;
      bus_rdata <= 8'h00;
    end else begin
      fs_prev_q <= frame_measure_input;
      if (ev_gain)
        synced_q <= 1'b1;
      else if (ev_lost)
        synced_q <= 1'b0;
      irq_q <= (irq_q & {5{~irq_clr}}) | irq_set;
      int_oe_n <= ~|irq_q;
      bus_rdata <= bus_rd ? rd_d : 8'h00;
      if (bus_wr) begin
        case (bus_addr)
          `TSW_A_MODE: mode_q <= bus_wdata;
          `TSW_A_SHIFT0: icss_q[7:0] <= bus_wdata;
          `TSW_A_SHIFT0 + 5'h01: icss_q[15:8] <= bus_wdata;
          `TSW_A_SHIFT0 + 5'h02: icss_q[23:16] <= bus_wdata;
          `TSW_A_SHIFT0 + 5'h03: icss_q[31:24] <= bus_wdata;
          `TSW_A_OSHIFT: oshift_q <= bus_wdata;
          `TSW_A_IALO: ia_lo_q <= bus_wdata;
          `TSW_A_IAHI: ia_hi_q <= bus_wdata;
          `TSW_A_IDLO: id_lo_q <= bus_wdata;
          default: ;
        endcase
      end
      if (wr_cmd & bus_wdata[`TSW_C_CMR] & ~cmr_busy_q) begin
        cmr_busy_q <= 1'b1;
        cmr_idx_q <= 10'h000;
      end else if (cmr_busy_q) begin
        cmr_idx_q <= cmr_idx_q + 10'h001;
        if (cmr_end)
          cmr_busy_q <= 1'b0;
      end
      if (wr_cmd & bus_wdata[`TSW_C_EVAL] &
          (bus_wdata[4:2] <= `TSW_FS_MAX)) begin
        ev_busy_q <= 1'b1;
        ev_sel_q <= bus_wdata[4:2];
      end else if (fs_hit) begin
        ev_busy_q <= 1'b0;
        edge_q <= in_cnt_q;
      end
      case (st_state_q)
        ST_IDLE: begin
          if (st_start) begin
            st_state_q <= ST_STEP1;
            st_cnt_q <= 32'h0000_0000;
            st_err_q <= mode_q[`TSW_M_PSB] & (icss_q != 32'h0);
            if (~mode_q[`TSW_M_PSB])
              icss_q <= 32'h0000_0000;
          end
        end
        ST_STEP1: begin
          st_cnt_q <= st_step_end ? 32'h0000_0000 : st_cnt_q + 32'h1;
          if (st_step_end)
            st_state_q <= ST_STEP2;
        end
        ST_STEP2: begin
          st_cnt_q <= st_cnt_q + 32'h1;
          if (st_mis)
            st_err_q <= 1'b1;
          if (st_step_end) begin
            st_state_q <= ST_CLEAR;
            cmr_busy_q <= 1'b1;
            cmr_idx_q <= 10'h000;
          end
        end
        ST_CLEAR: begin
          if (cmr_end) begin
            st_state_q <= ST_IDLE;
            st_ok_q <= ~st_err_q;
          end
        end
        default: st_state_q <= ST_IDLE;
      endcase
    end
  end

  always @* begin
    case (bus_addr)
      `TSW_A_MODE: rd_d = mode_q;
      `TSW_A_STAT: rd_d = {3'h0, synced_q, st_ok_q, st_run,
                           ev_busy_q, cmr_busy_q};
      `TSW_A_IRQ: rd_d = {3'h0, irq_q};
      `TSW_A_SHIFT0: rd_d = icss_q[7:0];
      `TSW_A_SHIFT0 + 5'h01: rd_d = icss_q[15:8];
      `TSW_A_SHIFT0 + 5'h02: rd_d = icss_q[23:16];
      `TSW_A_SHIFT0 + 5'h03: rd_d = icss_q[31:24];
      `TSW_A_OSHIFT: rd_d = oshift_q;
      `TSW_A_EDGELO: rd_d = edge_q[7:0];
      `TSW_A_EDGEHI: rd_d = {4'h0, edge_q[11:8]};
      `TSW_A_IALO: rd_d = ia_lo_q;
      `TSW_A_IAHI: rd_d = ia_hi_q;
      `TSW_A_IDLO: rd_d = ind_rd[7:0];
      `TSW_A_IDHI: rd_d = {4'h0, ind_rd[11:8]};
      default: rd_d = 8'h00;
    endcase
  end
endmodule
`default_nettype wire

// ===== rtl/tsw_regs.vh
// Register map, field positions and timing constants of the time slot switch.
// How it works
// - Any of 2048 input channels reaches any of 2048 output channels.
// - Every input frame is written into both byte-wide data memories.
// - A 12-bit input counter steps the writes and wraps once per frame.
// - An output counter reads connection entries that pick the byte sent.
// - Connection memory b feeds output lines 16 to 31, memory a the rest.
// - Sync pulse is sampled on the falling edge; its rise restarts counters.
// - Sixteen shift values; with 32 inputs each value serves a line pair.
// - One output shift value delays every output line alike.
// - Evaluate command picks input 0 to 5 and captures its next rising edge.
// - The captured input counter value is readable as a 12-bit figure.
// - Frame length is checked each frame; loss and regain raise interrupts.
// - Unused ports and slots flagged tristate release their output lines.
// - Byte registers are direct; memories go through four indirect bytes.
// - Status shows each special function busy; completion raises interrupt.
// - Control memory reset marks every entry tristate.
// - Selftest runs two 0.625 ms steps and reports pass or fail.
// - Selftest ends with a control memory reset.
// - Selftest can be started and read through the test access port.
// - Selftest needs shift value 00; loaded unless the select bit is set.
// - Scan cells: one per input, two per output, three per two-way pin.
// - Test port follows the standard with a 32-bit identification register.
// - Interrupt line is active-low open drain, released by interrupt register read.
// - A high reset input forces the reset state.
`ifndef TSW_REGS_VH
`define TSW_REGS_VH
`define TSW_A_MODE 5'h00
`define TSW_A_CMD 5'h01
`define TSW_A_STAT 5'h02
`define TSW_A_IRQ 5'h03
`define TSW_A_SHIFT0 5'h04
`define TSW_A_OSHIFT 5'h08
`define TSW_A_EDGELO 5'h09
`define TSW_A_EDGEHI 5'h0A
`define TSW_A_IALO 5'h0B
`define TSW_A_IAHI 5'h0C
`define TSW_A_IDLO 5'h0D
`define TSW_A_IDHI 5'h0E
`define TSW_M_PSB 0
`define TSW_M_WIDE 1
`define TSW_C_CMR 0
`define TSW_C_EVAL 1
`define TSW_C_ST 5
`define TSW_I_LOST 0
`define TSW_I_GAIN 1
`define TSW_I_CMR 2
`define TSW_I_EVAL 3
`define TSW_I_ST 4
`define TSW_IA_DM 7
`define TSW_FRAME_LAST 12'hFFF
`define TSW_SLOT_END 6'h3F
`define TSW_CM_TRI 12'h800
`define TSW_CMR_LAST 10'h3FF
`define TSW_FS_MAX 3'h5
`define TSW_CLK_NS 32'h0000_000A
`define TSW_STEP_NS 32'h0009_8968
`define TSW_IR_IDCODE 2'h1
`define TSW_IR_SELFTEST 2'h2
`define TSW_IR_BYPASS 2'h3
`define TSW_SCAN_IN_CELLS 2'h1
`define TSW_SCAN_OUT_CELLS 2'h2
`define TSW_SCAN_IO_CELLS 2'h3
`endif

// ===== test/tsw_props.sv
// Port checker of the time slot switch.
`timescale 1ns/1ps
`default_nettype none
`include "tsw_regs.vh"
module tsw_props (
  input wire logic clock,
  input wire logic rst,
  input wire logic [4:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_rdata,
  input wire logic [31:0] pcm_tx_oe_n,
  input wire logic int_out,
  input wire logic int_oe_n,
  input wire logic tdo_oe_n
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  logic wide_q;
  // Tracks the wide mode bit as software last wrote it.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wide_q <= 1'b0;
    end else if (bus_wr && bus_addr == `TSW_A_MODE) begin
      wide_q <= bus_wdata[`TSW_M_WIDE];
    end
  end
  logic [10:0] cmr_wait_q;
  // Counts cycles from a memory reset command until the interrupt line falls.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cmr_wait_q <= 11'h000;
    end else if (bus_wr && bus_addr == `TSW_A_CMD &&
                 bus_wdata[`TSW_C_CMR]) begin
      cmr_wait_q <= 11'h001;
    end else if (!int_oe_n) begin
      cmr_wait_q <= 11'h000;
    end else if (cmr_wait_q != 11'h000) begin
      cmr_wait_q <= cmr_wait_q + 11'h001;
    end
  end
  AST_RD_IDLE: assert property (!bus_rd |=> bus_rdata == 8'h00)
    else $error("read data not zero outside a read");
  AST_UNMAPPED: assert property (bus_rd && bus_addr > `TSW_A_IDHI
    |=> bus_rdata == 8'h00) else $error("unmapped read not zero");
  AST_INT_OD: assert property (int_out == 1'b0)
    else $error("interrupt data not low");
  AST_EDGE_HI: assert property (bus_rd && bus_addr == `TSW_A_EDGEHI
    |=> bus_rdata[7:4] == 4'h0) else $error("edge value wider than 12");
  AST_STAT_HI: assert property (bus_rd && bus_addr == `TSW_A_STAT
    |=> bus_rdata[7:5] == 3'h0) else $error("status spare bits set");
  AST_WIDE_TRI: assert property (!wide_q [*4]
    |-> &pcm_tx_oe_n[31:16]) else $error("upper lines driven");
  AST_RST: assert property (disable iff (1'b0) rst
    |-> &pcm_tx_oe_n && int_oe_n && tdo_oe_n) else $error("reset state");
  AST_CMR_IRQ: assert property (cmr_wait_q <= 11'h410)
    else $error("memory reset did not finish");
endmodule
bind tsw_core tsw_props tsw_props_inst (.clock(clock), .rst(rst),
  .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
  .bus_rd(bus_rd), .bus_rdata(bus_rdata), .pcm_tx_oe_n(pcm_tx_oe_n),
  .int_out(int_out), .int_oe_n(int_oe_n), .tdo_oe_n(tdo_oe_n));
`default_nettype wire

// ===== test/tsw_far.sv
// Far-side PCM highway model: frame sync, line bytes and edge markers.
`timescale 1ns/1ps
`default_nettype none
module tsw_far (
  input wire logic clock,
  input wire logic rst,
  input wire logic sync_en,
  output logic [31:0] pcm_rx_line,
  output logic sync_pulse,
  output logic [5:0] frame_measure_input
);
  logic [11:0] tick_q;
  logic [7:0] b;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tick_q <= 12'h000;
    end else begin
      tick_q <= tick_q + 12'h001;
    end
  end
  // Sync rises once per 4096 ticks; every line repeats its byte each slot.
  always_comb begin
    sync_pulse = sync_en && tick_q < 12'h008;
    for (int k = 0; k < 32; k++) begin
      b = 8'hA5 + 8'(k);
      pcm_rx_line[k] = b[3'h7 - tick_q[5:3]];
    end
    for (int i = 0; i < 6; i++) begin
      frame_measure_input[i] = tick_q >= 12'h0C8 + 12'(16 * i)
        && tick_q < 12'h3E8;
    end
  end
endmodule
`default_nettype wire

// ===== test/tb.sv
// Self-checking bench of the time slot switch.
`timescale 1ns/1ps
`default_nettype none
`include "tsw_regs.vh"
module tb;
  // Arbitrary identification value.
  localparam logic [31:0] ID = 32'h1234_5677;
  logic clock = 1'b0;
  logic rst = 1'b0;
  logic [4:0] bus_addr = 5'h00;
  logic [7:0] bus_wdata = 8'h00;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic tck = 1'b0;
  logic tms = 1'b1;
  logic tdi = 1'b1;
  logic sync_en = 1'b0;
  logic [7:0] bus_rdata;
  logic [7:0] v;
  logic [31:0] pcm_rx_line;
  logic [31:0] pcm_tx_line;
  logic [31:0] pcm_tx_oe_n;
  logic [5:0] frame_measure_input;
  logic sync_pulse;
  logic int_out;
  logic int_oe_n;
  logic tdo;
  logic tdo_oe_n;
  int mismatches = 0;
  int checked = 0;
  always #5 clock = ~clock;
  tsw_core #(.STEP_CYC(32'h0000_0040), .ID_CODE(ID)) tsw_core_inst (
    .clock(clock), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .pcm_rx_line(pcm_rx_line), .sync_pulse(sync_pulse),
    .frame_measure_input(frame_measure_input), .pcm_tx_line(pcm_tx_line),
    .pcm_tx_oe_n(pcm_tx_oe_n), .int_out(int_out), .int_oe_n(int_oe_n),
    .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n));
  tsw_far tsw_far_inst (.clock(clock), .rst(rst), .sync_en(sync_en),
    .pcm_rx_line(pcm_rx_line), .sync_pulse(sync_pulse),
    .frame_measure_input(frame_measure_input));
  ////////////////////////////////////////
  task automatic stop_test();
    if (mismatches == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic fail();
    mismatches++;
    stop_test();
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clock);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clock);
    bus_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge clock);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clock);
    bus_rd <= 1'b0;
    #1 d = bus_rdata;
  endtask
  task automatic rc(input logic [4:0] a, input logic [7:0] e);
    rd(a, v);
    chk(v, e);
  endtask
  task automatic waitint(input int n);
    int i;
    for (i = 0; i < n && int_oe_n !== 1'b0; i++) @(posedge clock);
    if (i == n) fail();
  endtask
  task automatic edge_rd(output logic [11:0] c);
    rd(`TSW_A_EDGELO, v);
    c[7:0] = v;
    rd(`TSW_A_EDGEHI, v);
    c[11:8] = v[3:0];
  endtask
  task automatic tick(input logic m, output logic o);
    tms <= m;
    repeat (6) @(posedge clock);
    o = tdo;
    tck <= 1'b1;
    repeat (4) @(posedge clock);
    tck <= 1'b0;
  endtask
  ////////////////////////////////////////
  task automatic t_cmr();
    chk(pcm_tx_oe_n, 32'hFFFF_FFFF);
    chk(int_oe_n, 1'b1);
    chk(tdo_oe_n, 1'b1);
    rc(5'h1F, 8'h00);
    wr(`TSW_A_CMD, 8'h01);
    rc(`TSW_A_STAT, 8'h01);
    waitint(1100);
    rc(`TSW_A_IRQ, 8'h04);
    rc(`TSW_A_STAT, 8'h00);
    chk(int_oe_n, 1'b1);
    repeat (70) @(posedge clock);
    chk(pcm_tx_oe_n, 32'hFFFF_FFFF);
  endtask
  task automatic t_sync(input logic on, input logic [7:0] irq);
    sync_en <= on;
    waitint(13000);
    rc(`TSW_A_IRQ, irq);
    rc(`TSW_A_STAT, {3'h0, on, 4'h0});
  endtask
  task automatic t_path(input int o, input int s);
    logic [10:0] ch;
    logic [10:0] ea;
    logic [7:0] b;
    int i;
    ch = 11'(64 + s);
    ea = {o >= 16, o[3:0], 6'h0A};
    b = 8'hA5 + 8'(s);
    wr(`TSW_A_IALO, ch[7:0]);
    wr(`TSW_A_IAHI, {5'h10, ch[10:8]});
    rc(`TSW_A_IDLO, b);
    wr(`TSW_A_IALO, ea[7:0]);
    wr(`TSW_A_IAHI, {5'h00, ea[10:8]});
    wr(`TSW_A_IDLO, ch[7:0]);
    wr(`TSW_A_IDHI, {5'h00, ch[10:8]});
    rc(`TSW_A_IDLO, ch[7:0]);
    rc(`TSW_A_IDHI, {5'h00, ch[10:8]});
    for (i = 0; i < 5000 && pcm_tx_oe_n[o] !== 1'b0; i++) @(posedge clock);
    if (i == 5000) fail();
    repeat (4) @(posedge clock);
    for (i = 7; i >= 0; i--) begin
      chk(pcm_tx_line[o], b[i]);
      repeat (8) @(posedge clock);
    end
    repeat (40) @(posedge clock);
    chk(pcm_tx_oe_n[o], 1'b1);
  endtask
  task automatic t_eval();
    logic [11:0] c0;
    logic [11:0] c;
    for (int i = 0; i < 7; i++) begin
      wr(`TSW_A_CMD, {3'h0, 3'(i), 2'h2});
      if (i > 5) begin
        rc(`TSW_A_STAT, 8'h10);
      end else begin
        waitint(5000);
        rc(`TSW_A_IRQ, 8'h08);
        edge_rd(c);
        if (i == 0) c0 = c;
        chk(c - c0, 12'(16 * i));
      end
    end
    repeat (4200) @(posedge clock);
    edge_rd(c0);
    chk(c0, c);
  endtask
  task automatic t_self(input logic [7:0] mode, input logic [7:0] st0,
                        input logic [7:0] st);
    wr(`TSW_A_MODE, mode);
    wr(`TSW_A_SHIFT0, 8'h01);
    wr(`TSW_A_CMD, 8'h20);
    rc(`TSW_A_STAT, st0);
    waitint(1400);
    rc(`TSW_A_IRQ, 8'h10);
    rc(`TSW_A_STAT, st);
    chk(pcm_tx_oe_n, 32'hFFFF_FFFF);
  endtask
  task automatic t_id();
    logic [31:0] id;
    logic o;
    for (int i = 0; i < 9; i++) tick(i < 5 || i == 6, o);
    for (int i = 0; i < 32; i++) begin
      tick(i == 31, o);
      if (i == 0) chk(tdo_oe_n, 1'b0);
      id[i] = o;
    end
    chk(id, ID);
  endtask
  task automatic t_tap();
    logic [13:0] s;
    logic o;
    s = 14'h1AC7;
    for (int i = 0; i < 14; i++) begin
      tdi <= (i != 5);
      tick(s[i], o);
    end
    rc(`TSW_A_STAT, 8'h1C);
    waitint(1400);
    rc(`TSW_A_IRQ, 8'h10);
    rc(`TSW_A_STAT, 8'h18);
    for (int i = 0; i < 4; i++) tick(i == 0 || i == 3, o);
    chk(o, 1'b1);
  endtask
  initial begin
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    t_cmr();
    t_sync(1'b1, 8'h02);
    wr(`TSW_A_MODE, 8'h02);
    t_path(3, 7);
    t_path(20, 9);
    t_eval();
    t_self(8'h02, 8'h14, 8'h18);
    rc(`TSW_A_SHIFT0, 8'h00);
    t_id();
    t_tap();
    t_self(8'h03, 8'h1C, 8'h10);
    t_sync(1'b0, 8'h01);
    stop_test();
  end
endmodule
`default_nettype wire
